/* dv/rcos_line_model.sv */
// line channel and external reference clock model
`timescale 1ns/100ps
module rcos_line_model (
  input wire [15:0] channel_e1_mode,
  input wire stop_a,
  input wire stop_b,
  input wire rate_a,
  input wire rate_b,
  output logic external_clock_a = 0,
  output logic external_clock_b = 0,
  output logic [15:0] recovered_clock_pre_ja = 0,
  output logic [15:0] recovered_clock_post_ja = 0
);
  // external clocks stand still while stopped
  always #(rate_a ? 244.1 : 323.8) if (!stop_a) external_clock_a = ~external_clock_a;
  always #(rate_b ? 244.1 : 323.8) if (!stop_b) external_clock_b = ~external_clock_b;
  for (genvar i = 0; i < 16; i++) begin : g_ch
    always #(channel_e1_mode[i] ? 244.1 : 323.8)
      recovered_clock_pre_ja[i] = ~recovered_clock_pre_ja[i];
    always @(recovered_clock_pre_ja[i])
      recovered_clock_post_ja[i] <= #100 recovered_clock_pre_ja[i];
  end
endmodule // rcos_line_model

/* dv/rcos_ref_clock_props.sv */
// assertion checker for the reference clock block
`timescale 1ns/100ps
module rcos_ref_clock_props (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire t1_timing_output_oe,
  input wire e1_timing_output_oe,
  input wire reference_output_a_oe,
  input wire reference_output_b_oe,
  input wire power_down,
  input wire line_pins_float,
  input wire transmit_inputs_ignored,
  input wire [15:0] receive_output_float_select,
  input wire [15:0] receive_pins_float,
  input wire auto_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // write that clears one bit of a register
  sequence wr_clr(a, b);
    psel && penable && pready && pwrite && paddr == a && !pwdata[b];
  endsequence
  a_t1_float: assert property (wr_clr(12'h000, 1) |=> ##[0:1] !t1_timing_output_oe)
    else $error("t1 timing output still driven");
  a_e1_float: assert property (wr_clr(12'h000, 3) |=> ##[0:1] !e1_timing_output_oe)
    else $error("e1 timing output still driven");
  a_reference_a_select_float: assert property (wr_clr(12'h004, 6) |=> ##[0:1] !reference_output_a_oe)
    else $error("reference a still driven");
  a_reference_b_select_float: assert property (wr_clr(12'h008, 6) |=> ##[0:1] !reference_output_b_oe)
    else $error("reference b still driven");
  a_pd_pins: assert property (power_down |-> line_pins_float && transmit_inputs_ignored)
    else $error("line pins active in power down");
  a_pd_rx_sel: assert property (power_down |-> receive_pins_float == receive_output_float_select)
    else $error("receive pins ignore float select");
  a_reset_cause: assert property ($rose(auto_reset) |-> $past(power_down) || $past(power_down, 2))
    else $error("automatic reset without power down");
  a_reset_pulse: assert property (auto_reset |=> !auto_reset)
    else $error("automatic reset longer than one cycle");
endmodule // rcos_ref_clock_props
bind rcos_ref_clock rcos_ref_clock_props rcos_ref_clock_props_i (.clock, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .t1_timing_output_oe, .e1_timing_output_oe,
  .reference_output_a_oe, .reference_output_b_oe, .power_down, .line_pins_float,
  .transmit_inputs_ignored, .receive_output_float_select, .receive_pins_float, .auto_reset);

/* dv/rcos_ref_clock_test.sv */
// self-checking bench for the reference clock block
`timescale 1ns/100ps
`include "rcos_regs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %s expected %0h seen %0h", n, e, g); end end
module rcos_ref_clock_test;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, master_clock_duty_low = 0;
  logic stop_a = 1, stop_b = 1, rate_a = 0, rate_b = 0, slv;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [15:0] channel_e1_mode = 0, line_signal_loss_status = 0, receive_output_float_select = 0;
  logic [3:0] master_clock_rate_straps = 0, ch = 0, cb = 0;
  logic [7:0] v;
  logic [11:0] offs[4] = '{12'h000, 12'h004, 12'h008, 12'h00C};
  logic [7:0] rsts[4] = '{8'h00, 8'h00, 8'h00, 8'h10};
  logic [7:0] msk[4] = '{8'h05, 8'h3f, 8'h3f, 8'h7f};
  wire [31:0] prdata;
  wire pready, pslverr, t1_timing_output, t1_timing_output_oe, e1_timing_output;
  wire e1_timing_output_oe, reference_output_a, reference_output_a_oe, reference_output_b;
  wire reference_output_b_oe, power_down, line_pins_float, transmit_inputs_ignored, auto_reset;
  wire external_clock_a, external_clock_b;
  wire [15:0] recovered_clock_pre_ja, recovered_clock_post_ja, channel_internal_reference;
  wire [15:0] receive_pins_float, receive_pins_low;
  wire [4:0] outs = {channel_internal_reference[ch], reference_output_b, reference_output_a,
    e1_timing_output, t1_timing_output};
  int err_total = 0, check_count = 0, seed = 32'hde1a664c, cnt[5], i, k, e;
  rcos_ref_clock rcos_ref_clock_i (.*);
  rcos_line_model rcos_line_model_i (.*);
  function automatic bit near(int g, int x, int t);
    return g >= x - t && g <= x + t;
  endfunction
  // expected rising edges in n cycles, saturating at one toggle a cycle
  function automatic int edges(longint hz, int n);
    edges = hz * n / 10000000;
    if (edges > n / 2) edges = n / 2;
  endfunction
  function automatic longint lr(bit e1);
    return e1 ? `RCOS_F_E1_LINE : `RCOS_F_T1_LINE;
  endfunction
  function automatic longint syn(int c);
    longint f[8] = '{8000, 64000, 2048000, 4096000, 8192000, 19440000, 32768000, 32768000};
    return f[c];
  endfunction
  task automatic apb(input bit w, input [11:0] a, input [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic meas(int n);
    logic [4:0] p;
    p = outs;
    cnt = '{default: 0};
    repeat (n) begin
      @(negedge clock);
      for (k = 0; k < 5; k++) cnt[k] += outs[k] & !p[k];
      p = outs;
    end
    @(posedge clock);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial forever #50 clock = ~clock;
  initial begin
    #9ms;
    err_total++;
    end_sim;
  end
  initial begin
    master_clock_rate_straps <= $random(seed);
    channel_e1_mode <= $random(seed);
    receive_output_float_select <= $random(seed);
    repeat (4) @(posedge clock);
    rst_n <= 1;
    for (i = 0; i < 4; i++) begin
      apb(0, offs[i], 0);
      `CHK("reset_value", {24'h0, rsts[i]}, rd)
      v = $random(seed) & msk[i];
      apb(1, offs[i], {24'h0, v});
      apb(0, offs[i], 0);
      `CHK("read_back", {24'h0, v}, rd)
    end
    apb(1, 12'h020, 32'hffff_ffff);
    `CHK("unmapped_err", 1'b1, slv)
    apb(0, 12'h020, 0);
    `CHK("unmapped_rd", 32'h0000_0000, rd)
    apb(0, `RCOS_OFF_STATUS, 0);
    `CHK("straps", master_clock_rate_straps, rd[7:4])
    for (i = 0; i < 3; i++) begin
      v = i == 0 ? 8'h0a : i == 1 ? 8'h0f : 8'h00;
      apb(1, `RCOS_OFF_TIMING, {24'h0, v});
      meas(12500);
      `CHK("t1_oe", v[1], t1_timing_output_oe)
      `CHK("e1_oe", v[3], e1_timing_output_oe)
      e = edges(v[0] ? `RCOS_F_T1_TIMING : `RCOS_F_8K, 12500);
      if (v[1]) `CHK("t1_rate", 1'b1, near(cnt[0], e, 1))
      e = edges(v[2] ? `RCOS_F_E1_TIMING : `RCOS_F_8K, 12500);
      if (v[3]) `CHK("e1_rate", 1'b1, near(cnt[1], e, 1))
    end
    for (i = 0; i < 2; i++) begin
      ch = $random(seed);
      cb = $random(seed);
      apb(1, `RCOS_OFF_CONFIG, {25'h0, 1'($random(seed)), 6'h10});
      apb(1, `RCOS_OFF_REFERENCE_A_SELECT, {24'h0, 4'h4, ch});
      apb(1, `RCOS_OFF_REFERENCE_B_SELECT, {24'h0, 4'h4, cb});
      meas(100);
      meas(2000);
      e = edges(lr(channel_e1_mode[ch]), 2000);
      `CHK("reference_a_select_rate", 1'b1, near(cnt[2], e, 4))
      `CHK("xref_rate", 1'b1, near(cnt[4], e, 4))
      `CHK("reference_b_select_rate", 1'b1, near(cnt[3], edges(lr(channel_e1_mode[cb]), 2000), 4))
      `CHK("ref_oe", 2'b11, {reference_output_a_oe, reference_output_b_oe})
      line_signal_loss_status <= (16'h1 << ch) | (16'h1 << cb);
      apb(1, `RCOS_OFF_CONFIG, 32'h30);
      meas(100);
      meas(300);
      `CHK("line_signal_loss_hold", 2'b11, {reference_output_a, reference_output_b})
      `CHK("line_signal_loss_edges", 0, cnt[2] + cnt[3])
      apb(1, `RCOS_OFF_CONFIG, 32'h10);
      meas(100);
      meas(2000);
      `CHK("line_signal_loss_lock", 1'b1, near(cnt[2], e, 4))
      `CHK("line_signal_loss_lock_b", 1'b1, near(cnt[3], edges(lr(channel_e1_mode[cb]), 2000), 4))
      line_signal_loss_status <= 0;
    end
    rate_a <= 1'($random(seed));
    rate_b <= 1'($random(seed));
    stop_a <= 0;
    stop_b <= 0;
    apb(1, `RCOS_OFF_CONFIG, 32'h30);
    apb(1, `RCOS_OFF_REFERENCE_A_SELECT, {24'h0, 2'b01, rate_a, 5'h1d});
    apb(1, `RCOS_OFF_REFERENCE_B_SELECT, {24'h0, 2'b01, rate_b, 5'h1f});
    meas(100);
    meas(2000);
    `CHK("ext_a_rate", 1'b1, near(cnt[2], edges(lr(rate_a), 2000), 4))
    `CHK("ext_b_rate", 1'b1, near(cnt[3], edges(lr(rate_b), 2000), 4))
    stop_a <= 1;
    stop_b <= 1;
    meas(100);
    meas(300);
    `CHK("ext_lost_high", 2'b11, {reference_output_a, reference_output_b})
    `CHK("ext_lost_edges", 0, cnt[2] + cnt[3])
    apb(0, `RCOS_OFF_STATUS, 0);
    `CHK("ext_lost_flags", 2'b11, rd[1:0])
    apb(1, `RCOS_OFF_CONFIG, 32'h10);
    meas(100);
    meas(2000);
    `CHK("ext_b_lock", 1'b1, near(cnt[3], edges(lr(rate_b), 2000), 4))
    `CHK("ext_a_lost", 0, cnt[2])
    for (i = 0; i < 9; i++) begin
      apb(1, `RCOS_OFF_CONFIG, i == 8 ? 32'h2 : 32'h8 + i);
      meas(100);
      meas(2000);
      e = (i == 0 || i == 3 || i == 8) ? 0 : edges(syn(i), 2000);
      `CHK("synth_rate", 1'b1, near(cnt[2], e, 4))
    end
    master_clock_duty_low <= 1;
    repeat (150) @(posedge clock);
    @(negedge clock);
    `CHK("pd", 3'b111, {power_down, line_pins_float, transmit_inputs_ignored})
    `CHK("rx_float", receive_output_float_select, receive_pins_float)
    `CHK("rx_low", ~receive_output_float_select, receive_pins_low)
    @(posedge clock);
    master_clock_duty_low <= 0;
    k = 0;
    repeat (20) begin
      @(negedge clock);
      if (auto_reset === 1'b1) k = 1;
    end
    `CHK("auto_reset", 1, k)
    apb(0, `RCOS_OFF_REFERENCE_A_SELECT, 0);
    `CHK("reset_reference_a_select", 32'h0000_0000, rd)
    end_sim;
  end
endmodule // rcos_ref_clock_test

/* verilog/rcos_ref_clock.v */
// reference clock output selection, timing outputs and master clock loss handling
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "rcos_regs.vh"
module rcos_ref_clock #(
  parameter CHANNELS = 16
) (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [CHANNELS-1:0] recovered_clock_pre_ja,
  input wire [CHANNELS-1:0] recovered_clock_post_ja,
  input wire [CHANNELS-1:0] channel_e1_mode,
  input wire [CHANNELS-1:0] line_signal_loss_status,
  input wire [CHANNELS-1:0] receive_output_float_select,
  input wire external_clock_a,
  input wire external_clock_b,
  input wire master_clock_duty_low,
  input wire [3:0] master_clock_rate_straps,
  output reg t1_timing_output,
  output reg t1_timing_output_oe,
  output reg e1_timing_output,
  output reg e1_timing_output_oe,
  output reg reference_output_a,
  output reg reference_output_a_oe,
  output reg reference_output_b,
  output reg reference_output_b_oe,
  output reg [CHANNELS-1:0] channel_internal_reference,
  output reg power_down,
  output reg line_pins_float,
  output reg [CHANNELS-1:0] receive_pins_float,
  output reg [CHANNELS-1:0] receive_pins_low,
  output reg transmit_inputs_ignored,
  output reg auto_reset
);
  localparam NCO_N = 5;
  localparam N_T1T = 0;
  localparam N_E1T = 1;
  localparam N_T1L = 2;
  localparam N_E1L = 3;
  localparam N_SYN = 4;
  localparam [2:0] FREQ_RSV_A = 3'h0;
  localparam [2:0] FREQ_RSV_B = 3'h3;

  reg [7:0] timing_output_control_q;
  reg [7:0] reference_a_select_q;
  reg [7:0] reference_b_select_q;
  reg [7:0] reference_output_config_q;
  reg [3:0] straps_q;
  reg strap_taken_q;
  reg [CHANNELS-1:0] rec_s1_q, rec_s2_q, pre_s1_q, pre_s2_q;
  reg [2:0] exta_q, extb_q;
  reg duty_s1_q, duty_s2_q;
  reg [7:0] lost_a_cnt_q, lost_b_cnt_q;
  reg lost_a_q, lost_b_q;
  reg [15:0] duty_cnt_q;
  reg pd_q;
  reg soft_rst_q;
  reg [NCO_N-1:0] nco_out_q;
  reg [63:0] nco_inc [0:NCO_N-1];
  reg [63:0] syn_inc;
  wire clr_n;

  // control registers, loss watchdogs, clock generators and clock output drivers cleared by pin reset or by master clock recovery
  assign clr_n = rst_n & ~soft_rst_q;

  // straps caught once after reset release
  always @(posedge clock) begin
    if (!rst_n) begin
      straps_q <= 4'h0;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      straps_q <= master_clock_rate_straps;
      strap_taken_q <= 1'b1;
    end
  end

  // apb slave, answer in first access cycle
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire mapped = (paddr == `RCOS_OFF_TIMING) || (paddr == `RCOS_OFF_REFERENCE_A_SELECT) ||
    (paddr == `RCOS_OFF_REFERENCE_B_SELECT) || (paddr == `RCOS_OFF_CONFIG) || (paddr == `RCOS_OFF_STATUS);
  reg [31:0] rd_d;
  always @* begin
    case (paddr)
      `RCOS_OFF_TIMING: rd_d = {24'h00_0000, timing_output_control_q};
      `RCOS_OFF_REFERENCE_A_SELECT: rd_d = {24'h00_0000, reference_a_select_q};
      `RCOS_OFF_REFERENCE_B_SELECT: rd_d = {24'h00_0000, reference_b_select_q};
      `RCOS_OFF_CONFIG: rd_d = {24'h00_0000, reference_output_config_q};
      `RCOS_OFF_STATUS: rd_d = {24'h00_0000, straps_q, 1'b0, pd_q, lost_b_q, lost_a_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  always @(posedge clock) begin
    if (!clr_n) begin
      timing_output_control_q <= `RCOS_RST_TIMING;
      reference_a_select_q <= `RCOS_RST_REFERENCE_A_SELECT;
      reference_b_select_q <= `RCOS_RST_REFERENCE_B_SELECT;
      reference_output_config_q <= `RCOS_RST_CONFIG;
    end else if (access && pwrite) begin
      case (paddr)
        `RCOS_OFF_TIMING: timing_output_control_q <= pwdata[7:0];
        `RCOS_OFF_REFERENCE_A_SELECT: reference_a_select_q <= pwdata[7:0];
        `RCOS_OFF_REFERENCE_B_SELECT: reference_b_select_q <= pwdata[7:0];
        `RCOS_OFF_CONFIG: reference_output_config_q <= pwdata[7:0];
        default: timing_output_control_q <= timing_output_control_q;
      endcase
    end
  end

  // pin synchronisers
  always @(posedge clock) begin
    if (!rst_n) begin
      {rec_s1_q, pre_s1_q} <= {(2*CHANNELS){1'b0}};
      {rec_s2_q, pre_s2_q} <= {(2*CHANNELS){1'b0}};
      exta_q <= 3'h0;
      extb_q <= 3'h0;
      duty_s1_q <= 1'b0;
      duty_s2_q <= 1'b0;
    end else begin
      {rec_s1_q, pre_s1_q} <= {recovered_clock_post_ja, recovered_clock_pre_ja};
      {rec_s2_q, pre_s2_q} <= {rec_s1_q, pre_s1_q};
      exta_q <= {exta_q[1:0], external_clock_a};
      extb_q <= {extb_q[1:0], external_clock_b};
      duty_s1_q <= master_clock_duty_low;
      duty_s2_q <= duty_s1_q;
    end
  end

  // external clock loss watchdogs
  wire edge_a = exta_q[2] ^ exta_q[1];
  wire edge_b = extb_q[2] ^ extb_q[1];
  wire [31:0] lim_a = reference_a_select_q[`RCOS_EXT_RATE_BIT] ?
    `RCOS_EXT_LOSS_E1_CYC : `RCOS_EXT_LOSS_T1_CYC;
  wire [31:0] lim_b = reference_b_select_q[`RCOS_EXT_RATE_BIT] ?
    `RCOS_EXT_LOSS_E1_CYC : `RCOS_EXT_LOSS_T1_CYC;
  always @(posedge clock) begin
    if (!clr_n) begin
      lost_a_cnt_q <= 8'h00;
      lost_b_cnt_q <= 8'h00;
      lost_a_q <= 1'b0;
      lost_b_q <= 1'b0;
    end else begin
      if (edge_a) begin
        lost_a_cnt_q <= 8'h00;
        lost_a_q <= 1'b0;
      end else if ({24'h00_0000, lost_a_cnt_q} < lim_a) begin
        lost_a_cnt_q <= lost_a_cnt_q + 8'h01;
      end else begin
        lost_a_q <= 1'b1;
      end
      if (edge_b) begin
        lost_b_cnt_q <= 8'h00;
        lost_b_q <= 1'b0;
      end else if ({24'h00_0000, lost_b_cnt_q} < lim_b) begin
        lost_b_cnt_q <= lost_b_cnt_q + 8'h01;
      end else begin
        lost_b_q <= 1'b1;
      end
    end
  end

  // master clock loss, power down and automatic reset
  always @(posedge clock) begin
    if (!rst_n) begin
      duty_cnt_q <= 16'h0000;
      pd_q <= 1'b0;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= 1'b0;
      if (duty_s2_q) begin
        if ({16'h0000, duty_cnt_q} < `RCOS_MCLK_LOSS_CYC) begin
          duty_cnt_q <= duty_cnt_q + 16'h0001;
        end else begin
          pd_q <= 1'b1;
        end
      end else begin
        duty_cnt_q <= 16'h0000;
        if (pd_q) begin
          pd_q <= 1'b0;
          soft_rst_q <= 1'b1;
        end
      end
    end
  end

  // synthesizer code assignment
  always @* begin
    case (reference_output_config_q[`RCOS_FREQ_MSB:0])
      3'h0: syn_inc = `RCOS_INC(8000);
      3'h1: syn_inc = `RCOS_INC(64000);
      3'h2: syn_inc = `RCOS_INC(2048000);
      3'h3: syn_inc = `RCOS_INC(4096000);
      3'h4: syn_inc = `RCOS_INC(8192000);
      3'h5: syn_inc = `RCOS_INC(19440000);
      default: syn_inc = `RCOS_INC(32768000);
    endcase
    nco_inc[N_T1T] = timing_output_control_q[`RCOS_T1_RATE_BIT] ?
      `RCOS_INC(`RCOS_F_T1_TIMING) : `RCOS_INC(`RCOS_F_8K);
    nco_inc[N_E1T] = timing_output_control_q[`RCOS_E1_RATE_BIT] ?
      `RCOS_INC(`RCOS_F_E1_TIMING) : `RCOS_INC(`RCOS_F_8K);
    nco_inc[N_T1L] = `RCOS_INC(`RCOS_F_T1_LINE);
    nco_inc[N_E1L] = `RCOS_INC(`RCOS_F_E1_LINE);
    nco_inc[N_SYN] = syn_inc;
  end

  // master-locked clock generators, toggling on accumulator carry
  genvar gi;
  generate
    for (gi = 0; gi < NCO_N; gi = gi + 1) begin : g_nco
      reg [31:0] acc_q;
      wire [36:0] sum = {5'h00, acc_q} + {1'b0, nco_inc[gi][35:0]};
      always @(posedge clock) begin
        if (!clr_n) begin
          acc_q <= 32'h0000_0000;
          nco_out_q[gi] <= 1'b0;
        end else begin
          acc_q <= sum[31:0];
          if (sum[36:32] != 5'h00) begin
            nco_out_q[gi] <= ~nco_out_q[gi];
          end
        end
      end
    end
  endgenerate

  // reference output selection
  wire [4:0] src_a = reference_a_select_q[`RCOS_SRC_MSB:0];
  wire [4:0] src_b = reference_b_select_q[`RCOS_SRC_MSB:0];
  wire hold = reference_output_config_q[`RCOS_HOLD_BIT];
  wire syn_on = ~reference_output_config_q[`RCOS_FS_BYPASS_BIT];
  wire free_run = syn_on & reference_output_config_q[`RCOS_FREE_BIT];
  wire [2:0] freq = reference_output_config_q[`RCOS_FREQ_MSB:0];
  wire freq_rsv = (freq == FREQ_RSV_A) || (freq == FREQ_RSV_B);
  wire ch_a_ok = {27'h000_0000, src_a} < CHANNELS;
  wire ch_b_ok = {27'h000_0000, src_b} < CHANNELS;
  wire [3:0] ch_a = src_a[3:0];
  wire [3:0] ch_b = src_b[3:0];
  wire ja_pre = reference_output_config_q[`RCOS_JA_TAP_BIT];
  wire [CHANNELS-1:0] rec_sync = ja_pre ? pre_s2_q : rec_s2_q;
  wire los_a = line_signal_loss_status[ch_a];
  wire los_b = line_signal_loss_status[ch_b];
  wire lock_a = channel_e1_mode[ch_a] ? nco_out_q[N_E1L] : nco_out_q[N_T1L];
  wire lock_b = channel_e1_mode[ch_b] ? nco_out_q[N_E1L] : nco_out_q[N_T1L];
  wire lock_xb = reference_b_select_q[`RCOS_EXT_RATE_BIT] ? nco_out_q[N_E1L] : nco_out_q[N_T1L];
  reg ref_a_d, ref_b_d;

  always @* begin
    ref_a_d = 1'b0;
    if (free_run) begin
      ref_a_d = freq_rsv ? 1'b1 : nco_out_q[N_SYN];
    end else if (src_a >= `RCOS_EXT_SEL_MIN) begin
      if (lost_a_q) begin
        ref_a_d = 1'b1;
      end else begin
        ref_a_d = syn_on ? nco_out_q[N_SYN] : exta_q[1];
      end
    end else if (ch_a_ok) begin
      if (los_a) begin
        ref_a_d = hold ? 1'b1 : (syn_on ? nco_out_q[N_SYN] : lock_a);
      end else begin
        ref_a_d = syn_on ? nco_out_q[N_SYN] : rec_sync[ch_a];
      end
    end
  end

  always @* begin
    ref_b_d = 1'b0;
    if (src_b >= `RCOS_EXT_SEL_MIN) begin
      if (lost_b_q) begin
        ref_b_d = hold ? 1'b1 : lock_xb;
      end else begin
        ref_b_d = extb_q[1];
      end
    end else if (ch_b_ok) begin
      if (los_b) begin
        ref_b_d = hold ? 1'b1 : lock_b;
      end else begin
        ref_b_d = rec_sync[ch_b];
      end
    end
  end

  // registered pin drivers
  always @(posedge clock) begin
    if (!clr_n) begin
      t1_timing_output <= 1'b0;
      t1_timing_output_oe <= 1'b0;
      e1_timing_output <= 1'b0;
      e1_timing_output_oe <= 1'b0;
      reference_output_a <= 1'b0;
      reference_output_a_oe <= 1'b0;
      reference_output_b <= 1'b0;
      reference_output_b_oe <= 1'b0;
      channel_internal_reference <= {CHANNELS{1'b0}};
    end else begin
      t1_timing_output <= nco_out_q[N_T1T];
      t1_timing_output_oe <= timing_output_control_q[`RCOS_T1_EN_BIT];
      e1_timing_output <= nco_out_q[N_E1T];
      e1_timing_output_oe <= timing_output_control_q[`RCOS_E1_EN_BIT];
      reference_output_a <= ref_a_d;
      reference_output_a_oe <= reference_a_select_q[`RCOS_REF_EN_BIT];
      reference_output_b <= ref_b_d;
      reference_output_b_oe <= reference_b_select_q[`RCOS_REF_EN_BIT];
      channel_internal_reference <= (channel_e1_mode & {CHANNELS{nco_out_q[N_E1L]}}) |
        (~channel_e1_mode & {CHANNELS{nco_out_q[N_T1L]}});
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      power_down <= 1'b0;
      line_pins_float <= 1'b0;
      receive_pins_float <= {CHANNELS{1'b0}};
      receive_pins_low <= {CHANNELS{1'b0}};
      transmit_inputs_ignored <= 1'b0;
      auto_reset <= 1'b0;
    end else begin
      power_down <= pd_q;
      line_pins_float <= pd_q;
      receive_pins_float <= {CHANNELS{pd_q}} & receive_output_float_select;
      receive_pins_low <= {CHANNELS{pd_q}} & ~receive_output_float_select;
      transmit_inputs_ignored <= pd_q;
      auto_reset <= soft_rst_q;
    end
  end
endmodule // rcos_ref_clock

/* verilog/rcos_regs.vh */
// register offsets, fields, reset values and timing counts for the reference clock block
`ifndef RCOS_REGS_VH
`define RCOS_REGS_VH
`define RCOS_OFF_TIMING 12'h000
`define RCOS_OFF_REFERENCE_A_SELECT 12'h004
`define RCOS_OFF_REFERENCE_B_SELECT 12'h008
`define RCOS_OFF_CONFIG 12'h00C
`define RCOS_OFF_STATUS 12'h010
`define RCOS_RST_TIMING 8'h00
`define RCOS_RST_REFERENCE_A_SELECT 8'h00
`define RCOS_RST_REFERENCE_B_SELECT 8'h00
`define RCOS_RST_CONFIG 8'h10
`define RCOS_T1_RATE_BIT 0
`define RCOS_T1_EN_BIT 1
`define RCOS_E1_RATE_BIT 2
`define RCOS_E1_EN_BIT 3
`define RCOS_SRC_MSB 4
`define RCOS_EXT_RATE_BIT 5
`define RCOS_REF_EN_BIT 6
`define RCOS_FREQ_MSB 2
`define RCOS_FREE_BIT 3
`define RCOS_FS_BYPASS_BIT 4
`define RCOS_HOLD_BIT 5
`define RCOS_JA_TAP_BIT 6
`define RCOS_EXT_SEL_MIN 5'h1D
`define RCOS_CLK_HZ 10000000
`define RCOS_CLK_PS 100000
`define RCOS_T1_PERIOD_PS 647668
`define RCOS_E1_PERIOD_PS 488281
`define RCOS_EXT_LOSS_PERIODS 8
`define RCOS_EXT_LOSS_T1_CYC ((`RCOS_EXT_LOSS_PERIODS*`RCOS_T1_PERIOD_PS+`RCOS_CLK_PS-1)/`RCOS_CLK_PS)
`define RCOS_EXT_LOSS_E1_CYC ((`RCOS_EXT_LOSS_PERIODS*`RCOS_E1_PERIOD_PS+`RCOS_CLK_PS-1)/`RCOS_CLK_PS)
`define RCOS_MCLK_LOSS_NS 10000
`define RCOS_MCLK_LOSS_CYC ((`RCOS_MCLK_LOSS_NS*1000+`RCOS_CLK_PS-1)/`RCOS_CLK_PS)
`define RCOS_F_8K 8000
`define RCOS_F_T1_TIMING 1544
`define RCOS_F_E1_TIMING 2048
`define RCOS_F_T1_LINE 1544000
`define RCOS_F_E1_LINE 2048000
`define RCOS_INC(f) (((f)*64'd8589934592)/`RCOS_CLK_HZ)
`endif
